// ---- logic/rosc_pkg.sv ----
/*
 Package for the radio operating state controller: operating states,
 host command codes and the packed command and status carriers.
 Assumes nothing beyond a SystemVerilog compiler; no timescale here.
*/
// ==========================================================
// Operating states, commands and carriers
package rosc_pkg;

   // Operating states of the controller
   typedef enum logic [2:0] {
      ROSC_SHUTDOWN,
      ROSC_READY,
      ROSC_LOCK,
      ROSC_TX,
      ROSC_RX,
      ROSC_SLEEP,
      ROSC_STANDBY
   } rosc_state_type;

   // Host command codes (chosen freely, no documented encoding)
   localparam logic [2:0] ROSC_CMD_READY = 3'h0;
   localparam logic [2:0] ROSC_CMD_LOCK = 3'h1;
   localparam logic [2:0] ROSC_CMD_TX = 3'h2;
   localparam logic [2:0] ROSC_CMD_RX = 3'h3;
   localparam logic [2:0] ROSC_CMD_SLEEP = 3'h4;
   localparam logic [2:0] ROSC_CMD_STANDBY = 3'h5;

   // Cycles spent in lock on an automatic pass between transmit and receive
   localparam int ROSC_LOCK_PASS_CYCLES = 2;

   // Reset value of the host-visible configuration word
   localparam logic [7:0] ROSC_CFG_RESET = 8'h00;

   // Command from the host as decoded from the serial port
   typedef struct packed {
      logic valid;
      logic [2:0] code;
   } rosc_cmd_type;

   // Status returned to the host
   typedef struct packed {
      logic [2:0] state;
      logic crystal_ok;
      logic local_osc_ok;
      logic cmd_rejected;
   } rosc_status_type;

endpackage

// ---- logic/rosc_pin_sync.sv ----
/*
 Two-flop synchroniser for one asynchronous level.
 Assumes a free-running clock and an active-low asynchronous reset.
*/
`timescale 1ns/1ps
// ==========================================================
// Level synchroniser
module rosc_pin_sync #(
   parameter logic RESET_VAL = 1'b1
) (
   input wire logic i_sys_clk,
   input wire logic i_rst_n,
   input wire logic i_level,
   output logic o_level
);
   logic meta_q;
   logic sync_q;

   // First flop feeds only the second
   always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         meta_q <= RESET_VAL;
         sync_q <= RESET_VAL;
      end else begin
         meta_q <= i_level;
         sync_q <= meta_q;
      end
   end

   assign o_level = sync_q;
endmodule

// ---- logic/rosc_controller.sv ----
/*
 Operating-state controller of a sub-GHz radio core. Commands from the
 serial host port move it among ready, lock, transmit, receive, sleep and
 standby; the power-off pin alone takes it into and out of shutdown.
 Assumes the command carrier comes from serial-port logic on i_sys_clk,
 and that the power-off pin is asynchronous (high means powered off).
*/
// Notes on behaviour
// - Power-off pin alone enters or leaves shutdown
// - Shutdown wipes all stored data and configuration
// - Shutdown floats GPIO and serial port outputs
// - Leaving shutdown lands in ready, crystal running
// - Ready may move to lock, oscillator generated
// - Transmit and receive swap only through lock
// - One host command triggers the lock pass
// - Activity returns to ready; ready enters sleep
// - Ready enters standby, keeping buffers and config
// - Other transitions only by host commands
`timescale 1ns/1ps
module rosc_controller #(
   parameter int GPIO_W = 4,
   parameter int CFG_W = 8
) (
   input wire logic i_sys_clk,
   input wire logic i_rst_n,
   input wire logic i_power_off_pin,
   input wire rosc_pkg::rosc_cmd_type i_cmd,
   input wire logic [CFG_W-1:0] i_cfg_wdata,
   input wire logic i_cfg_we,
   input wire logic [GPIO_W-1:0] i_gpio_out,
   input wire logic i_spi_miso,
   output rosc_pkg::rosc_status_type o_status,
   output logic [CFG_W-1:0] o_cfg,
   output logic [GPIO_W-1:0] o_gpio_out,
   output logic [GPIO_W-1:0] o_gpio_oe,
   output logic o_spi_miso,
   output logic o_spi_miso_oe,
   output logic o_crystal_reference_en,
   output logic o_local_osc_signal_en,
   output logic o_tx_en,
   output logic o_rx_en,
   output logic o_retain_en
);
   // ==========================================================
   // Power-off pin synchroniser
   logic off_sync;

   rosc_pin_sync #(
      .RESET_VAL(1'b1)
   ) u_off_sync (
      .i_sys_clk(i_sys_clk),
      .i_rst_n(i_rst_n),
      .i_level(i_power_off_pin),
      .o_level(off_sync)
   );

   // ==========================================================
   // State register and pending lock-pass target
   rosc_pkg::rosc_state_type state_q;
   rosc_pkg::rosc_state_type state_d;
   rosc_pkg::rosc_state_type target_q;
   rosc_pkg::rosc_state_type target_d;
   logic pass_q;
   logic pass_d;
   logic [1:0] pass_cnt_q;
   logic [1:0] pass_cnt_d;
   logic rej_q;
   logic rej_d;
   logic [CFG_W-1:0] cfg_q;
   logic [CFG_W-1:0] cfg_d;

   // Command decode
   wire cmd_v = i_cmd.valid;
   wire is_ready = cmd_v && (i_cmd.code == rosc_pkg::ROSC_CMD_READY);
   wire is_lock = cmd_v && (i_cmd.code == rosc_pkg::ROSC_CMD_LOCK);
   wire is_tx = cmd_v && (i_cmd.code == rosc_pkg::ROSC_CMD_TX);
   wire is_rx = cmd_v && (i_cmd.code == rosc_pkg::ROSC_CMD_RX);
   wire is_sleep = cmd_v && (i_cmd.code == rosc_pkg::ROSC_CMD_SLEEP);
   wire is_stby = cmd_v && (i_cmd.code == rosc_pkg::ROSC_CMD_STANDBY);
   wire pass_done = pass_cnt_q == 2'(rosc_pkg::ROSC_LOCK_PASS_CYCLES - 1);

   // Next-state logic
   always_comb begin
      state_d = state_q;
      target_d = target_q;
      pass_d = pass_q;
      pass_cnt_d = pass_cnt_q;
      rej_d = 1'b0;
      if (off_sync) begin
         state_d = rosc_pkg::ROSC_SHUTDOWN;
      end else begin
         case (state_q)
            rosc_pkg::ROSC_SHUTDOWN: begin
               state_d = rosc_pkg::ROSC_READY;
            end
            rosc_pkg::ROSC_READY: begin
               if (is_lock || is_tx || is_rx) begin
                  state_d = rosc_pkg::ROSC_LOCK;
                  pass_d = is_tx || is_rx;
                  target_d = is_rx ? rosc_pkg::ROSC_RX : rosc_pkg::ROSC_TX;
                  pass_cnt_d = 2'h0;
               end else if (is_sleep) begin
                  state_d = rosc_pkg::ROSC_SLEEP;
               end else if (is_stby) begin
                  state_d = rosc_pkg::ROSC_STANDBY;
               end else if (cmd_v) begin
                  rej_d = 1'b1;
               end
            end
            rosc_pkg::ROSC_LOCK: begin
               if (pass_q) begin
                  // Automatic pass; commands during it are rejected and dropped
                  rej_d = cmd_v;
                  pass_cnt_d = pass_cnt_q + 2'h1;
                  if (pass_done) begin
                     state_d = target_q;
                     pass_d = 1'b0;
                  end
               end else if (is_tx) begin
                  state_d = rosc_pkg::ROSC_TX;
               end else if (is_rx) begin
                  state_d = rosc_pkg::ROSC_RX;
               end else if (is_ready) begin
                  state_d = rosc_pkg::ROSC_READY;
               end else if (cmd_v) begin
                  rej_d = 1'b1;
               end
            end
            rosc_pkg::ROSC_TX,
            rosc_pkg::ROSC_RX: begin
               if ((is_rx && state_q == rosc_pkg::ROSC_TX)
                     || (is_tx && state_q == rosc_pkg::ROSC_RX)) begin
                  state_d = rosc_pkg::ROSC_LOCK;
                  pass_d = 1'b1;
                  target_d = is_rx ? rosc_pkg::ROSC_RX : rosc_pkg::ROSC_TX;
                  pass_cnt_d = 2'h0;
               end else if (is_ready) begin
                  state_d = rosc_pkg::ROSC_READY;
               end else if (is_lock) begin
                  state_d = rosc_pkg::ROSC_LOCK;
               end else if (cmd_v) begin
                  rej_d = 1'b1;
               end
            end
            rosc_pkg::ROSC_SLEEP,
            rosc_pkg::ROSC_STANDBY: begin
               if (is_ready) begin
                  state_d = rosc_pkg::ROSC_READY;
               end else if (cmd_v) begin
                  rej_d = 1'b1;
               end
            end
            default: begin
               state_d = rosc_pkg::ROSC_SHUTDOWN;
            end
         endcase
      end
   end

   // Configuration store, wiped in shutdown
   always_comb begin
      cfg_d = cfg_q;
      if (off_sync || state_q == rosc_pkg::ROSC_SHUTDOWN) begin
         cfg_d = CFG_W'(rosc_pkg::ROSC_CFG_RESET);
      end else if (i_cfg_we) begin
         cfg_d = i_cfg_wdata;
      end
   end

   // State and store flops
   always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         state_q <= rosc_pkg::ROSC_SHUTDOWN;
         target_q <= rosc_pkg::ROSC_TX;
         pass_q <= 1'b0;
         pass_cnt_q <= 2'h0;
         rej_q <= 1'b0;
         cfg_q <= CFG_W'(rosc_pkg::ROSC_CFG_RESET);
      end else begin
         state_q <= state_d;
         target_q <= target_d;
         pass_q <= pass_d;
         pass_cnt_q <= pass_cnt_d;
         rej_q <= rej_d;
         cfg_q <= cfg_d;
      end
   end

   // ==========================================================
   // Registered outputs from next state
   wire on_d = (state_d != rosc_pkg::ROSC_SHUTDOWN);
   wire xo_d = on_d && (state_d != rosc_pkg::ROSC_SLEEP)
      && (state_d != rosc_pkg::ROSC_STANDBY);
   wire lo_d = (state_d == rosc_pkg::ROSC_LOCK) || (state_d == rosc_pkg::ROSC_TX)
      || (state_d == rosc_pkg::ROSC_RX);

   // Pin drivers float in shutdown
   always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_gpio_out <= '0;
         o_gpio_oe <= '0;
         o_spi_miso <= 1'b0;
         o_spi_miso_oe <= 1'b0;
      end else begin
         o_gpio_out <= on_d ? i_gpio_out : '0;
         o_gpio_oe <= {GPIO_W{on_d}};
         o_spi_miso <= on_d ? i_spi_miso : 1'b0;
         o_spi_miso_oe <= on_d;
      end
   end

   // Analogue enables and status
   always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_crystal_reference_en <= 1'b0;
         o_local_osc_signal_en <= 1'b0;
         o_tx_en <= 1'b0;
         o_rx_en <= 1'b0;
         o_retain_en <= 1'b0;
         o_status <= '0;
         o_cfg <= CFG_W'(rosc_pkg::ROSC_CFG_RESET);
      end else begin
         o_crystal_reference_en <= xo_d;
         o_local_osc_signal_en <= lo_d;
         o_tx_en <= state_d == rosc_pkg::ROSC_TX;
         o_rx_en <= state_d == rosc_pkg::ROSC_RX;
         o_retain_en <= on_d;
         o_status <= '{state: state_d, crystal_ok: xo_d, local_osc_ok: lo_d,
                       cmd_rejected: rej_d};
         o_cfg <= cfg_d;
      end
   end
endmodule

// ---- bench/rosc_ctrl_assertions.sv ----
/* Checker on the ports of the radio state controller.
   Assumes one clock and an active-low asynchronous reset. */
`timescale 1ns/1ps
// ==========================================================
// Port checker
module rosc_ctrl_assertions #(
   parameter int GPIO_W = 4,
   parameter int CFG_W = 8
) (
   input wire logic i_sys_clk,
   input wire logic i_rst_n,
   input wire logic i_power_off_pin,
   input wire rosc_pkg::rosc_cmd_type i_cmd,
   input wire logic i_cfg_we,
   input wire rosc_pkg::rosc_status_type o_status,
   input wire logic [CFG_W-1:0] o_cfg,
   input wire logic [GPIO_W-1:0] o_gpio_oe,
   input wire logic o_spi_miso_oe,
   input wire logic o_crystal_reference_en,
   input wire logic o_local_osc_signal_en
);
   // Shorthands for state, pin and command
   wire logic [2:0] st = o_status.state;
   wire logic on = !i_power_off_pin;
   wire logic [2:0] cd = i_cmd.code;
   wire logic cv = i_cmd.valid;
   default clocking @(posedge i_sys_clk); endclocking
   default disable iff (!i_rst_n);
   a_off_floats_io: assert property (st == 3'h0 |-> !o_gpio_oe && !o_spi_miso_oe && !o_cfg)
      else $error("pins driven or config kept while off");
   a_wake_to_ready: assert property (st == 3'h0 ##1 st != 3'h0 |-> st == 3'h1 && o_crystal_reference_en)
      else $error("wake did not land in ready");
   a_lock_osc_on: assert property (st == 3'h2 |-> o_local_osc_signal_en)
      else $error("lock without local oscillator");
   a_no_direct_swap: assert property (st inside {3'h3, 3'h4} |=> !(st inside {3'h3, 3'h4}) || $stable(st))
      else $error("direct swap between transmit and receive");
   a_pin_off_stop: assert property (i_power_off_pin [*4] |=> st == 3'h0)
      else $error("power-off pin did not stop the core");
   a_idle_holds: assert property (on [*4] ##0 (!cv && st inside {3'h1, 3'h3, 3'h4, 3'h5, 3'h6}) |=> $stable(st))
      else $error("state moved without a command");
   a_reject_keeps: assert property (on [*4] ##0 (cv && st == 3'h5 && cd != 3'h0) |=> st == 3'h5 && o_status.cmd_rejected)
      else $error("illegal command not ignored");
   a_auto_lock: assert property (on [*4] ##0 (cv && st == 3'h3 && cd == 3'h3) |=> st == 3'h2 [*2] ##1 st == 3'h4)
      else $error("swap did not pass through lock");
   a_standby_keeps: assert property (st == 3'h6 && !i_cfg_we |=> $stable(o_cfg))
      else $error("standby lost configuration");
endmodule
bind rosc_controller rosc_ctrl_assertions #(.GPIO_W(GPIO_W), .CFG_W(CFG_W)) chk_inst (
   .i_sys_clk(i_sys_clk), .i_rst_n(i_rst_n), .i_power_off_pin(i_power_off_pin), .i_cmd(i_cmd),
   .i_cfg_we(i_cfg_we), .o_status(o_status), .o_cfg(o_cfg), .o_gpio_oe(o_gpio_oe),
   .o_spi_miso_oe(o_spi_miso_oe), .o_crystal_reference_en(o_crystal_reference_en),
   .o_local_osc_signal_en(o_local_osc_signal_en));

// ---- bench/rosc_host_model.sv ----
/* Host model that issues operating-state commands.
   Assumes the command carrier is sampled on the rising clock edge. */
`timescale 1ns/1ps
// ==========================================================
// Host command issuer
module rosc_host_model (
   input wire logic i_sys_clk,
   output rosc_pkg::rosc_cmd_type o_cmd
);
   initial o_cmd = '0;
   // One single-cycle pulse per request, changed just after an edge
   task automatic send(input logic [2:0] code);
      @(posedge i_sys_clk);
      #1 o_cmd = {1'b1, code};
      @(posedge i_sys_clk);
      #1 o_cmd = '0;
   endtask
endmodule

// ---- bench/radio_operating_state_controller_tb.sv ----
/* Self-checking bench for the radio state controller.
   Assumes the host model drives commands and the bench drives the pin. */
`timescale 1ns/1ps
// ==========================================================
// Bench top
module radio_operating_state_controller_tb;
   logic i_sys_clk = 1'b0;
   logic i_rst_n = 1'b0;
   logic pin = 1'b1;
   logic we = 1'b0;
   logic [7:0] wd = 8'h00;
   logic [3:0] gp = 4'h0;
   logic miso = 1'b0;
   logic [7:0] cfg_v;
   logic [7:0] cfg;
   logic [3:0] goe;
   logic moe;
   logic txe;
   logic rxe;
   logic xoe;
   logic loe;
   logic rte;
   logic mso;
   logic [3:0] gpo;
   logic [3:0] nxt;
   logic [2:0] prev = 3'h0;
   logic [3:0] exp_q[$];
   int errors = 0;
   int samples_checked = 0;
   rosc_pkg::rosc_cmd_type cmd;
   rosc_pkg::rosc_status_type stat;
   always #5 i_sys_clk = ~i_sys_clk;
   rosc_controller rosc_controller_inst (
      .i_sys_clk(i_sys_clk), .i_rst_n(i_rst_n), .i_power_off_pin(pin), .i_cmd(cmd),
      .i_cfg_wdata(wd), .i_cfg_we(we), .i_gpio_out(gp), .i_spi_miso(miso), .o_status(stat),
      .o_cfg(cfg), .o_gpio_out(gpo), .o_gpio_oe(goe), .o_spi_miso(mso), .o_spi_miso_oe(moe),
      .o_crystal_reference_en(xoe), .o_local_osc_signal_en(loe), .o_tx_en(txe),
      .o_rx_en(rxe), .o_retain_en(rte));
   rosc_host_model rosc_host_model_inst (.i_sys_clk(i_sys_clk), .o_cmd(cmd));
   // Compare and count one value
   task automatic check(input string what, input logic [7:0] e, input logic [7:0] g);
      samples_checked++;
      if (g !== e) begin
         errors++;
         $display("ERROR %s expected %0h seen %0h", what, e, g);
      end
   endtask
   // Expected enables of a state: transmit, receive, crystal, oscillator, retain
   function automatic logic [7:0] en_of(input logic [2:0] s);
      en_of = {3'h0, s == 3'h3, s == 3'h4, s inside {3'h1, 3'h2, 3'h3, 3'h4},
               s inside {3'h2, 3'h3, 3'h4}, s != 3'h0};
   endfunction
   // Note expected results, then issue the command
   task automatic go(input logic [2:0] c, input logic [3:0] a, input logic [3:0] b = 4'hF);
      exp_q.push_back(a);
      if (b != 4'hF) exp_q.push_back(b);
      rosc_host_model_inst.send(c);
      repeat (4) @(posedge i_sys_clk);
   endtask
   // Move the power-off pin and note the state it leads to
   task automatic power(input logic off, input logic [3:0] n);
      exp_q.push_back(n);
      @(posedge i_sys_clk);
      #1 pin = off;
      repeat (6) @(posedge i_sys_clk);
   endtask
   // Verdict and end of run
   task automatic conclude();
      $display("errors %0d samples_checked %0d", errors, samples_checked);
      if (errors == 0 && samples_checked > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask
   // Each state change or refusal takes the oldest note
   always @(posedge i_sys_clk) begin
      #2;
      if (stat.state !== prev || stat.cmd_rejected === 1'b1) begin
         nxt = exp_q.size() > 0 ? exp_q.pop_front() : 4'hF;
         check("state", {4'h0, nxt}, {4'h0, stat.cmd_rejected, stat.state});
         check("enables", en_of(nxt[2:0]), {3'h0, txe, rxe, xoe, loe, rte});
         check("pins", (nxt[2:0] != 3'h0) ? {3'h0, miso, gp} : 8'h00, {3'h0, mso, gpo});
         prev = stat.state;
      end
   end
   // Main sequence
   initial begin
      void'($urandom(32'h0b160be4));
      repeat (4) @(posedge i_sys_clk);
      #1 i_rst_n = 1'b1;
      gp = 4'($urandom);
      miso = 1'($urandom);
      power(1'b0, 4'h1);
      cfg_v = 8'($urandom) | 8'h01;
      #1 wd = cfg_v;
      we = 1'b1;
      @(posedge i_sys_clk);
      #1 we = 1'b0;
      @(posedge i_sys_clk);
      go(3'h1, 4'h2);
      go(3'h3, 4'h4);
      go(3'h2, 4'h2, 4'h3);
      go(3'h3, 4'h2, 4'h4);
      go(3'h0, 4'h1);
      go(3'h2, 4'h2, 4'h3);
      go(3'h0, 4'h1);
      go(3'h4, 4'h5);
      go(3'h2, 4'hD);
      go(3'h0, 4'h1);
      go(3'h5, 4'h6);
      check("cfg", cfg_v, cfg);
      go(3'h0, 4'h1);
      go(3'h6, 4'h9);
      go(3'h7, 4'h9);
      power(1'b1, 4'h0);
      check("oe", 8'h00, {3'h0, moe, goe});
      power(1'b0, 4'h1);
      check("cfg", rosc_pkg::ROSC_CFG_RESET, cfg);
      for (int i = 0; i < 20 && exp_q.size() > 0; i++) @(posedge i_sys_clk);
      if (exp_q.size() > 0) check("queue", 8'h00, 8'(exp_q.size()));
      conclude();
   end
endmodule
